// [common/twm_defines.svh]
// Register offsets, field positions, reset values and count limits of the
// 8-bit timer waveform-mode block.
// Assumes a 32-bit APB slave with one aligned word per register.
//
// How it works
// RULE1: Any nonzero channel A action bit hands the pin over to compare output A.
// RULE2: Software must also enable the pin's output driver outside this block.
// RULE3: Channel action fields are read according to the selected wave mode.
// RULE4: Non-PWM channel A: off, toggle, clear or set on match.
// RULE5: Fast PWM channel A 0/1: off unless top mode bit, then toggle.
// RULE6: Fast PWM channel A: 1/0 clear on match set at TOP; 1/1 inverse.
// RULE7: Phase PWM channel A 0/1: off unless top mode bit, then toggle.
// RULE8: Phase PWM channel A 1/0: clear on up match, set on down; 1/1 inverse.
// RULE9: PWM with compare equal TOP and high action bit: match ignored, TOP action kept.
// RULE10: Any nonzero channel B action bit hands the pin over to compare output B.
// RULE11: Non-PWM channel B: off, toggle, clear or set on match.
// RULE12: Fast PWM channel B: 0/1 reserved, 1/0 clear-match set-TOP, 1/1 inverse.
// RULE13: Phase PWM channel B: 0/1 reserved, 1/0 clear-up set-down, 1/1 inverse.
// RULE14: Control A bits 3 and 2 always read zero.
// RULE15: Two low mode bits plus top mode bit in control B select the mode.
// RULE16: Modes 0,1,2: TOP, compare update and overflow point as tabled.
// RULE17: Modes 3,5,7 as tabled; modes 4 and 6 reserved.
// RULE18: MAX is the all-ones 8-bit count.
// RULE19: Fast PWM counts up to TOP then clears to BOTTOM next tick.
// RULE20: Phase PWM counts up to TOP, holds one tick, counts down to BOTTOM. Here the counter goes from TOP to TOP-1 on the next tick, with no hold.
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH

// -------------------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------------------
`define TWM_OFF_CTRL_A   12'h000
`define TWM_OFF_CTRL_B   12'h004
`define TWM_OFF_COUNT    12'h008
`define TWM_OFF_CMP_A    12'h00C
`define TWM_OFF_CMP_B    12'h010
`define TWM_OFF_FLAGS    12'h014

// -------------------------------------------------------------------------
// Field positions
// -------------------------------------------------------------------------
`define TWM_CA_OUT_A_MSB 7
`define TWM_CA_OUT_A_LSB 6
`define TWM_CA_OUT_B_MSB 5
`define TWM_CA_OUT_B_LSB 4
`define TWM_CA_WAVE_MSB  1
`define TWM_CA_WAVE_LSB  0
`define TWM_CB_TOP_BIT   3
`define TWM_CB_CLK_MSB   2
`define TWM_CB_CLK_LSB   0
`define TWM_FL_OVF       0
`define TWM_FL_MATCH_A   1
`define TWM_FL_MATCH_B   2

// -------------------------------------------------------------------------
// Reset values, write masks and count limits
// -------------------------------------------------------------------------
`define TWM_RST_BYTE     8'h00
`define TWM_CA_WMASK     8'hF3
`define TWM_CB_WMASK     8'h0F
`define TWM_FL_WMASK     8'h07
`define TWM_CNT_MAX      8'hFF
`define TWM_CNT_BOTTOM   8'h00

`endif

// [common/twm_pkg.sv]
// Types shared by the timer waveform-mode block and its output units.
// Assumes the constants of twm_defines.svh for all figures.
package twm_pkg;

  // -----------------------------------------------------------------------
  // Waveform kinds and overflow points
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {TWM_KIND_NORMAL, TWM_KIND_CTC, TWM_KIND_FAST, TWM_KIND_PHASE} twm_kind_t;
  typedef enum logic [1:0] {TWM_FLAG_MAX, TWM_FLAG_TOP, TWM_FLAG_BOTTOM} twm_flag_at_t;

  // Decoded wave mode
  typedef struct packed {
    twm_kind_t    kind;
    logic         top_from_a;
    logic         buffered;
    twm_flag_at_t flag_at;
  } twm_mode_t;

  // Per-channel events handed to an output unit
  typedef struct packed {
    twm_kind_t kind;
    logic      dir_up;
    logic      match;
    logic      top_evt;
    logic      val_eq_top;
  } twm_chan_evt_t;

endpackage : twm_pkg

// [rtl/twm_compare_out.sv]
// One compare output unit: turns match and TOP events into a pin level.
// Assumes events are one-cycle pulses from the counter in twm_timer.
`timescale 1ns/1ps
module twm_compare_out #(
  parameter bit IS_CHAN_A = 1'b1
) (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   srst_i,
  // Events and configuration
  input  wire twm_pkg::twm_chan_evt_t evt_i,
  input  wire logic [1:0]             action_i,
  input  wire logic                   top_bit_i,
  // Pin side
  output logic                        out_o,
  output logic                        override_o
);

  logic out_reg;
  logic out_next;
  logic pwm;
  logic ignore_match;
  logic toggle_ok;

  // PWM kinds drop a match at TOP when the high action bit is set
  assign pwm          = (evt_i.kind == twm_pkg::TWM_KIND_FAST) || (evt_i.kind == twm_pkg::TWM_KIND_PHASE);
  assign ignore_match = pwm & evt_i.val_eq_top & action_i[1]; // [RULE9]
  // Toggle in PWM only for channel A with top mode bit; B treats it as reserved
  assign toggle_ok    = IS_CHAN_A & top_bit_i; // [RULE5] [RULE7] [RULE12] [RULE13]

  // Next output level by kind and action
  always_comb
  begin
    out_next = out_reg;
    case (evt_i.kind) // [RULE3]
      twm_pkg::TWM_KIND_NORMAL, twm_pkg::TWM_KIND_CTC:
      begin
        if (evt_i.match && action_i == 2'b01)
          out_next = ~out_reg; // [RULE4] [RULE11]
        else if (evt_i.match && action_i[1])
          out_next = action_i[0]; // [RULE4] [RULE11]
      end
      twm_pkg::TWM_KIND_FAST:
      begin
        if (action_i == 2'b01)
        begin
          if (evt_i.match && toggle_ok)
            out_next = ~out_reg; // [RULE5]
        end
        else if (action_i[1] && evt_i.top_evt)
          out_next = ~action_i[0]; // [RULE6] [RULE12]
        else if (action_i[1] && evt_i.match && !ignore_match)
          out_next = action_i[0]; // [RULE6] [RULE12]
      end
      twm_pkg::TWM_KIND_PHASE:
      begin
        if (action_i == 2'b01)
        begin
          if (evt_i.match && toggle_ok)
            out_next = ~out_reg; // [RULE7]
        end
        else if (action_i[1] && evt_i.top_evt && ignore_match)
          out_next = ~action_i[0]; // [RULE9]
        else if (action_i[1] && evt_i.match && !ignore_match)
          out_next = evt_i.dir_up ? action_i[0] : ~action_i[0]; // [RULE8] [RULE13]
      end
      default: out_next = out_reg;
    endcase
  end

  // Output level register
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      out_reg <= 1'b0;
    else
      out_reg <= out_next;
  end

  assign out_o      = out_reg;
  assign override_o = |action_i; // [RULE1] [RULE10]

  // Checks
  nonpwm_toggle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE4]
    (evt_i.kind == twm_pkg::TWM_KIND_NORMAL && action_i == 2'b01 && evt_i.match) |=> (out_o != $past(out_o)))
    else $error("toggle on match missing");
  fast_top_set_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE6]
    (evt_i.kind == twm_pkg::TWM_KIND_FAST && action_i == 2'b10 && evt_i.top_evt) |=> out_o)
    else $error("fast pwm not set at top");
  phase_down_set_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE8]
    (evt_i.kind == twm_pkg::TWM_KIND_PHASE && action_i == 2'b10 && evt_i.match && !evt_i.dir_up
     && !evt_i.val_eq_top) |=> out_o)
    else $error("phase pwm not set on down match");

endmodule : twm_compare_out

// [rtl/twm_timer.sv]
// Timer waveform-mode block: APB registers, 8-bit counter and two compare
// outputs whose pin override follows the channel action fields.
// Assumes an APB master on clk_sys_i; pin direction is set outside.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "twm_defines.svh"
module twm_timer #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              srst_i,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Compare output pins
  output logic                   compare_out_a_o,
  output logic                   compare_out_a_override_o,
  output logic                   compare_out_b_o,
  output logic                   compare_out_b_override_o
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  logic [7:0]         ctrl_a_reg;
  logic [7:0]         ctrl_b_reg;
  logic [7:0]         count_reg;
  logic [7:0]         count_next;
  logic [7:0]         cmp_a_buf_reg;
  logic [7:0]         cmp_b_buf_reg;
  logic [7:0]         cmp_a_act_reg;
  logic [7:0]         cmp_b_act_reg;
  logic [2:0]         flags_reg;
  logic               dir_up_reg;
  logic               dir_up_next;
  logic               block_reg;
  logic [31:0]        prdata_reg;
  logic [7:0]         top_val;
  logic               tick;
  logic               at_top;
  logic               at_max;
  logic               at_bottom_down;
  logic               match_a;
  logic               match_b;
  logic               ovf_evt;
  logic               wr_en;
  logic               addr_hit;
  logic               count_wr;
  twm_pkg::twm_mode_t mode;
  twm_pkg::twm_chan_evt_t evt_a;
  twm_pkg::twm_chan_evt_t evt_b;

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------

  // Wave mode decode: mode number to kind, TOP source, update and flag point
  function automatic twm_pkg::twm_mode_t decode_mode(input logic [2:0] wm);
    twm_pkg::twm_mode_t m;
    m.kind       = twm_pkg::TWM_KIND_NORMAL;
    m.top_from_a = 1'b0;
    m.buffered   = 1'b0;
    m.flag_at    = twm_pkg::TWM_FLAG_MAX;
    case (wm) // [RULE15]
      3'd0: m.kind = twm_pkg::TWM_KIND_NORMAL; // [RULE16]
      3'd1:
      begin
        m.kind     = twm_pkg::TWM_KIND_PHASE; // [RULE16]
        m.buffered = 1'b1;
        m.flag_at  = twm_pkg::TWM_FLAG_BOTTOM;
      end
      3'd2:
      begin
        m.kind       = twm_pkg::TWM_KIND_CTC; // [RULE16]
        m.top_from_a = 1'b1;
      end
      3'd3:
      begin
        m.kind     = twm_pkg::TWM_KIND_FAST; // [RULE17]
        m.buffered = 1'b1;
      end
      3'd5:
      begin
        m.kind       = twm_pkg::TWM_KIND_PHASE; // [RULE17]
        m.top_from_a = 1'b1;
        m.buffered   = 1'b1;
        m.flag_at    = twm_pkg::TWM_FLAG_BOTTOM;
      end
      3'd7:
      begin
        m.kind       = twm_pkg::TWM_KIND_FAST; // [RULE17]
        m.top_from_a = 1'b1;
        m.buffered   = 1'b1;
        m.flag_at    = twm_pkg::TWM_FLAG_TOP;
      end
      // Reserved codes 4 and 6 fall back to plain counting, never stall
      default: m.kind = twm_pkg::TWM_KIND_NORMAL; // [RULE17]
    endcase
    return m;
  endfunction : decode_mode

  // Register address match
  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    return a == ADDR_W'(off);
  endfunction : is_reg

  // -----------------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------------

  // Decode; zero wait states, unmapped addresses answer with pslverr
  assign addr_hit = is_reg(paddr, `TWM_OFF_CTRL_A) || is_reg(paddr, `TWM_OFF_CTRL_B)
                 || is_reg(paddr, `TWM_OFF_COUNT)  || is_reg(paddr, `TWM_OFF_CMP_A)
                 || is_reg(paddr, `TWM_OFF_CMP_B)  || is_reg(paddr, `TWM_OFF_FLAGS);
  assign wr_en    = psel & penable & pwrite & addr_hit;
  assign count_wr = wr_en & is_reg(paddr, `TWM_OFF_COUNT);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_hit;
  assign prdata   = prdata_reg;

  // Read data captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      prdata_reg <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata_reg <= 32'h0000_0000;
      if (is_reg(paddr, `TWM_OFF_CTRL_A))
        prdata_reg[7:0] <= ctrl_a_reg & `TWM_CA_WMASK; // [RULE14]
      else if (is_reg(paddr, `TWM_OFF_CTRL_B))
        prdata_reg[7:0] <= ctrl_b_reg;
      else if (is_reg(paddr, `TWM_OFF_COUNT))
        prdata_reg[7:0] <= count_reg;
      else if (is_reg(paddr, `TWM_OFF_CMP_A))
        prdata_reg[7:0] <= cmp_a_buf_reg;
      else if (is_reg(paddr, `TWM_OFF_CMP_B))
        prdata_reg[7:0] <= cmp_b_buf_reg;
      else if (is_reg(paddr, `TWM_OFF_FLAGS))
        prdata_reg[2:0] <= flags_reg;
    end
  end

  // Control registers; reserved bits never stored
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ctrl_a_reg <= `TWM_RST_BYTE;
      ctrl_b_reg <= `TWM_RST_BYTE;
    end
    else if (wr_en && is_reg(paddr, `TWM_OFF_CTRL_A))
      ctrl_a_reg <= pwdata[7:0] & `TWM_CA_WMASK; // [RULE14]
    else if (wr_en && is_reg(paddr, `TWM_OFF_CTRL_B))
      ctrl_b_reg <= pwdata[7:0] & `TWM_CB_WMASK;
  end

  // Mode from two low bits plus the top bit of control B
  assign mode = decode_mode({ctrl_b_reg[`TWM_CB_TOP_BIT], ctrl_a_reg[`TWM_CA_WAVE_MSB:`TWM_CA_WAVE_LSB]}); // [RULE15]

  // -----------------------------------------------------------------------
  // Compare values
  // -----------------------------------------------------------------------

  // Software-facing buffers
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      cmp_a_buf_reg <= `TWM_RST_BYTE;
      cmp_b_buf_reg <= `TWM_RST_BYTE;
    end
    else if (wr_en && is_reg(paddr, `TWM_OFF_CMP_A))
      cmp_a_buf_reg <= pwdata[7:0];
    else if (wr_en && is_reg(paddr, `TWM_OFF_CMP_B))
      cmp_b_buf_reg <= pwdata[7:0];
  end

  // Active values: follow at once, or only at TOP in PWM to avoid glitches
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      cmp_a_act_reg <= `TWM_RST_BYTE;
      cmp_b_act_reg <= `TWM_RST_BYTE;
    end
    else if (!mode.buffered || (tick && at_top)) // [RULE16]
    begin
      cmp_a_act_reg <= cmp_a_buf_reg;
      cmp_b_act_reg <= cmp_b_buf_reg;
    end
  end

  // -----------------------------------------------------------------------
  // Counter
  // -----------------------------------------------------------------------

  // Nonzero clock select runs the counter every cycle; no prescaler here
  assign tick           = |ctrl_b_reg[`TWM_CB_CLK_MSB:`TWM_CB_CLK_LSB];
  assign top_val        = mode.top_from_a ? cmp_a_act_reg : `TWM_CNT_MAX; // [RULE16] [RULE17]
  assign at_top         = count_reg == top_val;
  assign at_max         = count_reg == `TWM_CNT_MAX; // [RULE18]
  assign at_bottom_down = (count_reg == `TWM_CNT_BOTTOM) && !dir_up_reg;

  // Count sequence per kind
  always_comb
  begin
    count_next  = count_reg;
    dir_up_next = (mode.kind == twm_pkg::TWM_KIND_PHASE) ? dir_up_reg : 1'b1; // Single slope always counts up
    case (mode.kind)
      twm_pkg::TWM_KIND_NORMAL: count_next = count_reg + 8'h01;
      twm_pkg::TWM_KIND_CTC, twm_pkg::TWM_KIND_FAST:
        count_next = at_top ? `TWM_CNT_BOTTOM : count_reg + 8'h01; // [RULE19]
      twm_pkg::TWM_KIND_PHASE:
      begin
        if (dir_up_reg && at_top)
        begin
          dir_up_next = 1'b0; // [RULE20]
          count_next  = count_reg - 8'h01;
        end
        else if (at_bottom_down)
        begin
          dir_up_next = 1'b1; // [RULE20]
          count_next  = count_reg + 8'h01;
        end
        else
          count_next = dir_up_reg ? count_reg + 8'h01 : count_reg - 8'h01;
      end
      default: count_next = count_reg;
    endcase
  end

  // Counter register; a software write wins over the tick
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      count_reg  <= `TWM_RST_BYTE;
      dir_up_reg <= 1'b1;
    end
    else if (count_wr)
      count_reg <= pwdata[7:0];
    else if (tick)
    begin
      count_reg  <= count_next;
      dir_up_reg <= dir_up_next;
    end
  end

  // Match blocked on the tick after a count write, as software expects
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      block_reg <= 1'b0;
    else if (count_wr)
      block_reg <= 1'b1;
    else if (tick)
      block_reg <= 1'b0;
  end

  // -----------------------------------------------------------------------
  // Events and flags
  // -----------------------------------------------------------------------
  assign match_a = tick & ~block_reg & ~count_wr & (count_reg == cmp_a_act_reg);
  assign match_b = tick & ~block_reg & ~count_wr & (count_reg == cmp_b_act_reg);

  // Overflow point chosen by mode
  always_comb
  begin
    case (mode.flag_at)
      twm_pkg::TWM_FLAG_MAX:    ovf_evt = tick & ~count_wr & at_max; // [RULE16] [RULE18]
      twm_pkg::TWM_FLAG_TOP:    ovf_evt = tick & ~count_wr & at_top; // [RULE17]
      twm_pkg::TWM_FLAG_BOTTOM: ovf_evt = tick & ~count_wr & at_bottom_down; // [RULE16]
      default:                  ovf_evt = 1'b0;
    endcase
  end

  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      flags_reg <= 3'b000;
    else
    begin
      if (wr_en && is_reg(paddr, `TWM_OFF_FLAGS))
        flags_reg <= (flags_reg & ~pwdata[2:0]) | {match_b, match_a, ovf_evt};
      else
        flags_reg <= flags_reg | {match_b, match_a, ovf_evt};
    end
  end

  // -----------------------------------------------------------------------
  // Compare output units
  // -----------------------------------------------------------------------
  assign evt_a = '{kind: mode.kind, dir_up: dir_up_reg, match: match_a,
                   top_evt: tick & ~count_wr & at_top & dir_up_reg, val_eq_top: cmp_a_act_reg == top_val};
  assign evt_b = '{kind: mode.kind, dir_up: dir_up_reg, match: match_b,
                   top_evt: tick & ~count_wr & at_top & dir_up_reg, val_eq_top: cmp_b_act_reg == top_val};

  // Channel A
  twm_compare_out #(.IS_CHAN_A(1'b1)) u_out_a (
    .clk_sys_i  (clk_sys_i),
    .srst_i     (srst_i),
    .evt_i      (evt_a),
    .action_i   (ctrl_a_reg[`TWM_CA_OUT_A_MSB:`TWM_CA_OUT_A_LSB]),
    .top_bit_i  (ctrl_b_reg[`TWM_CB_TOP_BIT]),
    .out_o      (compare_out_a_o),
    .override_o (compare_out_a_override_o) // [RULE1] [RULE2]
  );

  // Channel B
  twm_compare_out #(.IS_CHAN_A(1'b0)) u_out_b (
    .clk_sys_i  (clk_sys_i),
    .srst_i     (srst_i),
    .evt_i      (evt_b),
    .action_i   (ctrl_a_reg[`TWM_CA_OUT_B_MSB:`TWM_CA_OUT_B_LSB]),
    .top_bit_i  (ctrl_b_reg[`TWM_CB_TOP_BIT]),
    .out_o      (compare_out_b_o),
    .override_o (compare_out_b_override_o) // [RULE10]
  );

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  ctrl_rsv_zero_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE14]
    (psel && !penable && !pwrite && is_reg(paddr, `TWM_OFF_CTRL_A)) |=> (prdata[3:2] == 2'b00))
    else $error("reserved control bits read nonzero");
  pin_override_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE1]
    compare_out_a_override_o == (ctrl_a_reg[7:6] != 2'b00))
    else $error("channel a override mismatch");
  pin_override_b_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE10]
    compare_out_b_override_o == (ctrl_a_reg[5:4] != 2'b00))
    else $error("channel b override mismatch");
  fast_wrap_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE19]
    (mode.kind == twm_pkg::TWM_KIND_FAST && tick && at_top && !count_wr) |=> (count_reg == 8'h00))
    else $error("fast pwm did not clear after top");
  phase_turn_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE20]
    (mode.kind == twm_pkg::TWM_KIND_PHASE && tick && at_top && dir_up_reg && !count_wr && top_val != 8'h00)
    |=> (!dir_up_reg && count_reg == $past(count_reg) - 8'h01))
    else $error("phase pwm did not turn at top");
  ovf_max_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE18]
    (mode.kind == twm_pkg::TWM_KIND_NORMAL && tick && count_reg == 8'hFF && !count_wr)
    |=> (flags_reg[0] && count_reg == 8'h00))
    else $error("overflow at max missing");
  ovf_bottom_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE16]
    (mode.flag_at == twm_pkg::TWM_FLAG_BOTTOM && tick && at_bottom_down && !count_wr) |=> flags_reg[0])
    else $error("overflow at bottom missing");
  cmp_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE17]
    (mode.buffered && !(tick && at_top) && $stable(mode)) |=> $stable(cmp_a_act_reg))
    else $error("buffered compare changed away from top");
  cover_fast_pwm: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    mode.kind == twm_pkg::TWM_KIND_FAST && evt_a.top_evt);
  cover_phase_turn: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    mode.kind == twm_pkg::TWM_KIND_PHASE && at_bottom_down && tick);
  cover_ctc_match: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    mode.kind == twm_pkg::TWM_KIND_CTC && match_a);

endmodule : twm_timer

// [testbench/twm_pin_model.sv]
// Pad model for one compare output pin: port latch, direction and override.
// Assumes a pull-up on the pad while its output driver is off.
`timescale 1ns/1ps
module twm_pin_model (
  // Pin control from software and the timer
  input  wire logic dir_out_i,
  input  wire logic port_val_i,
  input  wire logic override_i,
  input  wire logic cmp_level_i,
  // Pad level
  output logic      pad_o
);
  // Driver off lets the pull-up win, so no waveform reaches the pad
  assign pad_o = dir_out_i ? (override_i ? cmp_level_i : port_val_i) : 1'b1;
endmodule : twm_pin_model

// [testbench/twm_timer_bench.sv]
// Self-checking bench for the timer waveform block over APB.
// Assumes zero or more APB wait states and pads modelled by twm_pin_model.
`timescale 1ns/1ps
`include "twm_defines.svh"
module twm_timer_bench;
  logic clk_sys_i, srst_i, psel, penable, pwrite, pready, pslverr, out_a, ov_a, out_b, ov_b, dir_a, pad_a, pad_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err;
  int          errors, n_tests, t;
  // Mode table: control A, expected high time of pad A
  logic [7:0]  tca [6] = '{8'h83, 8'hC3, 8'h81, 8'hC1, 8'h40, 8'h42};
  int          thi [6] = '{17, 239, 32, 478, 256, 17};

  twm_timer DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_out_a_o(out_a), .compare_out_a_override_o(ov_a), .compare_out_b_o(out_b),
    .compare_out_b_override_o(ov_b));
  twm_pin_model pin_a (.dir_out_i(dir_a), .port_val_i(1'b0), .override_i(ov_a), .cmp_level_i(out_a), .pad_o(pad_a));
  twm_pin_model pin_b (.dir_out_i(1'b1), .port_val_i(1'b0), .override_i(ov_b), .cmp_level_i(out_b), .pad_o(pad_b));

  // ---------------------------------------------------------------------
  // Clock, 50 ns period
  // ---------------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic give_verdict();
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer, held until pready is seen high with the access phase
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
    if (n >= 50)
    begin
      errors++;
      give_verdict();
    end
  endtask : apb

  // Length of one whole high phase of pad A, bounded against a stuck pin
  task automatic high_time(output int hi);
    int n;
    n = 0;
    hi = 0;
    while (pad_a !== 1'b1 && n < 3000) begin @(posedge clk_sys_i); n++; end
    while (pad_a !== 1'b0 && n < 3000) begin @(posedge clk_sys_i); n++; end
    while (pad_a !== 1'b1 && n < 3000) begin @(posedge clk_sys_i); n++; end
    while (pad_a === 1'b1 && n < 3000) begin @(posedge clk_sys_i); n++; hi++; end
    if (n >= 3000)
    begin
      errors++;
      give_verdict();
    end
  endtask : high_time

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, errors, n_tests} = '0;
    srst_i = 1'b1;
    dir_a  = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    apb(1'b0, `TWM_OFF_CTRL_A, 8'h00);
    check("ctrl_a reset", rd, 32'h0000_0000);
    check("override reset", {ov_a, ov_b}, 32'h0000_0000);
    apb(1'b1, `TWM_OFF_CTRL_A, 8'hFF);
    apb(1'b0, `TWM_OFF_CTRL_A, 8'h00);
    check("ctrl_a reserved", rd, 32'h0000_00F3);
    check("override both", {ov_a, ov_b}, 32'h0000_0003);
    apb(1'b0, 12'h0FC, 8'h00);
    check("unmapped err", err, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    // Compare value loaded in normal mode, where it takes effect at once
    apb(1'b1, `TWM_OFF_CTRL_A, 8'h00);
    apb(1'b1, `TWM_OFF_CMP_A, 8'h10);
    apb(1'b1, `TWM_OFF_CTRL_B, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, `TWM_OFF_CTRL_A, tca[i]);
      high_time(t);
      check("pad a high time", t, thi[i]);
    end
    // Mode 7: TOP from compare A, toggle needs the top mode bit
    apb(1'b1, `TWM_OFF_CTRL_B, 8'h09);
    apb(1'b1, `TWM_OFF_CTRL_A, 8'h53);
    high_time(t);
    check("mode7 toggle", t, 32'd17);
    // Reserved fast PWM action on B must leave its level alone
    t = 0;
    rd[0] = pad_b;
    repeat (600) @(posedge clk_sys_i) t += (pad_b !== rd[0]);
    check("b reserved", t, 32'd0);
    dir_a <= 1'b0;
    @(posedge clk_sys_i);
    check("pad a undriven", pad_a, 32'h0000_0001);
    give_verdict();
  end
endmodule : twm_timer_bench
